// >>> rtl/sorc_top.sv
// What this block does
// - One-hot control lines select monitoring case 1 to 4.
// - No line high or several lines high flags a case error.
// - Internal mode drives outputs from field 1 and simultaneous field.
// - Field 2 pair never touches local outputs; it goes to the link.
// - External output mode sends every field status over the link.
// - With local outputs unused, link reports output state as active.
// - Evaluated protective field reports 1 when clear, 0 when infringed.
// - Non-evaluated protective field reports 1 by default.
// - Unallocated-as-infringed option reports non-evaluated fields as 0.
// - Feedback checked after each cut and before restart; fault keeps off.
// - Feedback fault without interlock or with delay locks out, with code.
// - Feedback fault with interlock: outputs off, indicator lit, code.
// - Three restart modes: none, timed delay, interlock with operator reset.
// - Without interlock, outputs return as soon as the field is clear.
// - Delay mode waits for a clear field of 2 to 60 seconds.
// - Interlock mode cuts outputs on entry and keeps them off afterwards.
// - Interlock mode restores outputs only after an operator reset press.
// - A reset press restores outputs only while the field is clear.
`timescale 1ns/1ps
module sorc_top
   import sorc_pkg::*;
#(
   parameter int TICKS_PER_SEC  = CLK_HZ,
   parameter int FB_SETTLE_CYC  = FB_SETTLE_MS * (CLK_HZ / 1000)
) (
   input  wire logic              CLOCK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic [DATA_W-1:0] WDATA_IN,
   input  wire logic              WSTROBE_IN,
   input  wire logic              RSTROBE_IN,
   input  wire logic              PAIR_A_LINE_ONE_IN,
   input  wire logic              PAIR_A_LINE_TWO_IN,
   input  wire logic              PAIR_B_LINE_ONE_IN,
   input  wire logic              PAIR_B_LINE_TWO_IN,
   input  wire logic              RESET_SWITCH_IN,
   input  wire logic              CONTACTOR_FEEDBACK_MONITOR_IN,
   input  wire logic              PF1_CLEAR_IN,
   input  wire logic              SIM_PF1_CLEAR_IN,
   input  wire logic              PF2_CLEAR_IN,
   input  wire logic              SIM_PF2_CLEAR_IN,
   input  wire logic              WF1_CLEAR_IN,
   input  wire logic              WF2_CLEAR_IN,
   output logic      [DATA_W-1:0] RDATA_OUT,
   output logic                   SAFETY_SWITCH_OUTPUT_OUT,
   output logic      [6:0]        LINK_STATUS_OUT,
   output logic                   LOCKOUT_OUT,
   output logic                   FAULT_LED_OUT,
   output logic      [3:0]        ERROR_CODE_OUT,
   output logic      [CASE_W-1:0] MONITOR_CASE_OUT,
   output logic                   CASE_ERROR_OUT
);

   localparam int TICK_W   = $clog2(TICKS_PER_SEC + 1);
   localparam int SETTLE_W = $clog2(FB_SETTLE_CYC + 1);
   localparam logic [TICK_W-1:0]   TICK_LAST =
      TICK_W'(TICKS_PER_SEC - 1);
   localparam logic [SETTLE_W-1:0] SETTLE_FULL = SETTLE_W'(FB_SETTLE_CYC);

   typedef enum logic [2:0] {
      ST_OFF, ST_DELAY, ST_WAIT_RESET, ST_ON, ST_FB_FAULT, ST_LOCKOUT
   } sorc_state_t;

   logic [LINE_W-1:0] lines_s;
   logic [1:0]        misc_s;
   logic              reset_sw_s;
   logic              feedback_s;
   logic [CASE_W-1:0] case_w;
   logic              case_err_w;

   // The second stages feed the case decode, reset edge and feedback checks; the field inputs are used unsynchronised.
   sorc_sync #(.W(LINE_W + 2)) u_sync (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RST_N_IN),
      .d_in     ({CONTACTOR_FEEDBACK_MONITOR_IN, RESET_SWITCH_IN,
                  PAIR_B_LINE_TWO_IN, PAIR_B_LINE_ONE_IN,
                  PAIR_A_LINE_TWO_IN, PAIR_A_LINE_ONE_IN}),
      .q_out    ({misc_s, lines_s})
   );

   assign reset_sw_s = misc_s[0];
   assign feedback_s = misc_s[1];

   sorc_case_decode u_case (
      .clk_in   (CLOCK_IN),
      .rst_n_in (RST_N_IN),
      .lines_in (lines_s),
      .case_out (case_w),
      .err_out  (case_err_w)
   );

   sorc_cfg_t          cfg_d, cfg_q;
   logic [DELAY_W-1:0] delay_d, delay_q;
   logic [DATA_W-1:0]  rdata_d, rdata_q;
   logic [DATA_W-1:0]  status_w;

   always_comb begin
      cfg_d   = cfg_q;
      delay_d = delay_q;
      rdata_d = 32'h0000_0000;
      if (WSTROBE_IN) begin
         if (ADDR_IN == OFS_CFG) begin
            cfg_d = sorc_cfg_t'(WDATA_IN[CFG_W-1:0]);
         end else if (ADDR_IN == OFS_DELAY) begin
            if (WDATA_IN[DELAY_W-1:0] < DELAY_MIN) begin
               delay_d = DELAY_MIN;
            end else if (WDATA_IN[DELAY_W-1:0] > DELAY_MAX) begin
               delay_d = DELAY_MAX;
            end else begin
               delay_d = WDATA_IN[DELAY_W-1:0];
            end
         end
      end
      if (RSTROBE_IN) begin
         if (ADDR_IN == OFS_CFG) begin
            rdata_d = {21'h000000, cfg_q};
         end else if (ADDR_IN == OFS_DELAY) begin
            rdata_d = {26'h0000000, delay_q};
         end else if (ADDR_IN == OFS_STATUS) begin
            rdata_d = status_w;
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cfg_q   <= sorc_cfg_t'(CFG_RST);
         delay_q <= DELAY_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         cfg_q   <= cfg_d;
         delay_q <= delay_d;
         rdata_q <= rdata_d;
      end
   end

   // Field 2 pair is left out of the local decision on purpose.
   logic local_clear;
   assign local_clear = (!cfg_q.eval_mask[0] || PF1_CLEAR_IN) &&
                        (!cfg_q.eval_mask[1] || SIM_PF1_CLEAR_IN);

   sorc_state_t        st_d, st_q;
   logic               on_d, on_q;
   logic               rsw_d, rsw_q;
   logic               reset_pulse;
   logic [TICK_W-1:0]  tick_d, tick_q;
   logic [DELAY_W-1:0] sec_d, sec_q;
   logic [SETTLE_W-1:0] settle_d, settle_q;
   logic               settle_done;
   logic               fb_fault_now;
   logic               fb_ok;
   logic [3:0]         err_d, err_q;
   logic               led_d, led_q;
   logic               lock_d, lock_q;
   sorc_link_t         link_d, link_q;

   assign reset_pulse   = reset_sw_s && !rsw_q;
   assign settle_done   = (settle_q == SETTLE_FULL);
   assign fb_fault_now  = cfg_q.fb_mon_en && !on_q && settle_done &&
                          !feedback_s;
   assign fb_ok         = !cfg_q.fb_mon_en || (settle_done && feedback_s);

   function automatic logic field_report(input logic evaluated,
                                         input logic clear,
                                         input logic unalloc);
      return evaluated ? clear : !unalloc;
   endfunction : field_report

   always_comb begin
      st_d     = st_q;
      rsw_d    = reset_sw_s;
      tick_d   = tick_q;
      sec_d    = sec_q;
      settle_d = on_q ? '0 :
                 (settle_done ? settle_q : settle_q + 1'b1);
      case (st_q)
         ST_OFF: begin
            if (local_clear) begin
               if (cfg_q.restart_mode == RM_INTERLOCK) begin
                  st_d = ST_WAIT_RESET;
               end else if (cfg_q.restart_mode == RM_DELAY) begin
                  st_d   = ST_DELAY;
                  tick_d = '0;
                  sec_d  = '0;
               end else if (fb_ok) begin
                  st_d = ST_ON;
               end
            end
         end
         ST_DELAY: begin
            if (!local_clear) begin
               st_d = ST_OFF;
            end else if (sec_q >= delay_q && fb_ok) begin
               st_d = ST_ON;
            end else if (tick_q == TICK_LAST) begin
               tick_d = '0;
               sec_d  = (sec_q == DELAY_MAX) ? sec_q : sec_q + 1'b1;
            end else begin
               tick_d = tick_q + 1'b1;
            end
         end
         ST_WAIT_RESET: begin
            if (reset_pulse && local_clear && fb_ok) begin
               st_d = ST_ON;
            end
         end
         ST_ON: begin
            if (!local_clear) begin
               st_d = (cfg_q.restart_mode == RM_INTERLOCK) ?
                      ST_WAIT_RESET : ST_OFF;
            end
         end
         ST_FB_FAULT: begin
            if (reset_pulse && feedback_s) begin
               st_d = ST_WAIT_RESET;
            end
         end
         ST_LOCKOUT: begin
            st_d = ST_LOCKOUT;
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
      if (fb_fault_now && st_q != ST_LOCKOUT) begin
         st_d = (cfg_q.restart_mode == RM_INTERLOCK) ?
                ST_FB_FAULT : ST_LOCKOUT;
      end
      on_d   = (st_d == ST_ON) && (cfg_q.out_mode == OM_INTERNAL);
      lock_d = (st_d == ST_LOCKOUT);
      led_d  = (st_d == ST_FB_FAULT);
      if (st_d == ST_LOCKOUT || st_d == ST_FB_FAULT) begin
         err_d = ERR_FB;
      end else if (case_err_w) begin
         err_d = ERR_CASE;
      end else begin
         err_d = ERR_NONE;
      end
      link_d.out_active = (cfg_q.out_mode == OM_UNUSED) ?
                          1'b1 : on_d;
      link_d.pf1     = field_report(cfg_q.eval_mask[0], PF1_CLEAR_IN,
                                    cfg_q.unalloc_infringed);
      link_d.sim_pf1 = field_report(cfg_q.eval_mask[1], SIM_PF1_CLEAR_IN,
                                    cfg_q.unalloc_infringed);
      link_d.pf2     = field_report(cfg_q.dual_pf && cfg_q.eval_mask[2],
                                    PF2_CLEAR_IN,
                                    cfg_q.unalloc_infringed);
      link_d.sim_pf2 = field_report(cfg_q.dual_pf && cfg_q.eval_mask[3],
                                    SIM_PF2_CLEAR_IN,
                                    cfg_q.unalloc_infringed);
      link_d.wf1     = WF1_CLEAR_IN;
      link_d.wf2     = WF2_CLEAR_IN;
   end

   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         st_q     <= ST_OFF;
         on_q     <= 1'b0;
         rsw_q    <= 1'b1;
         tick_q   <= '0;
         sec_q    <= '0;
         settle_q <= '0;
         err_q    <= ERR_NONE;
         led_q    <= 1'b0;
         lock_q   <= 1'b0;
         link_q   <= '0;
      end else begin
         st_q     <= st_d;
         on_q     <= on_d;
         rsw_q    <= rsw_d;
         tick_q   <= tick_d;
         sec_q    <= sec_d;
         settle_q <= settle_d;
         err_q    <= err_d;
         led_q    <= led_d;
         lock_q   <= lock_d;
         link_q   <= link_d;
      end
   end

   always_comb begin
      status_w                 = 32'h0000_0000;
      status_w[ST_BIT_ON]      = on_q;
      status_w[ST_BIT_LOCK]    = lock_q;
      status_w[ST_BIT_RSTREQ]  = (st_q == ST_WAIT_RESET);
      status_w[ST_BIT_FB]      = led_q;
      status_w[ST_BIT_CASEERR] = case_err_w;
      status_w[ST_CASE_LSB +: CASE_W] = case_w;
      status_w[ST_ERR_LSB +: 4] = err_q;
   end

   assign RDATA_OUT                = rdata_q;
   assign SAFETY_SWITCH_OUTPUT_OUT = on_q;
   assign LINK_STATUS_OUT          = link_q;
   assign LOCKOUT_OUT              = lock_q;
   assign FAULT_LED_OUT            = led_q;
   assign ERROR_CODE_OUT           = err_q;
   assign MONITOR_CASE_OUT         = case_w;
   assign CASE_ERROR_OUT           = case_err_w;

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);

   AST_ON_NEEDS_CLEAR: assert property (
      $rose(on_q) |-> $past(local_clear))
      else $error("Outputs came on with the field occupied.");
   AST_NONE_IMMEDIATE: assert property (
      st_q == ST_OFF && local_clear && cfg_q.restart_mode == RM_NONE &&
      !cfg_q.fb_mon_en && cfg_q.out_mode == OM_INTERNAL |=> on_q)
      else $error("Outputs did not return at once without interlock.");
   AST_FIELD_CUTS: assert property (
      on_q && !local_clear && !fb_fault_now |=> !on_q)
      else $error("Outputs stayed on with the field occupied.");
   AST_INTERLOCK_HOLD: assert property (
      st_q == ST_WAIT_RESET && !reset_pulse |=> !on_q)
      else $error("Outputs came on without an operator reset.");
   AST_RESET_NEEDS_CLEAR: assert property (
      $rose(on_q) && $past(st_q) == ST_WAIT_RESET |->
      $past(reset_pulse) && $past(local_clear))
      else $error("Reset press accepted with the field occupied.");
   AST_DELAY_WAIT: assert property (
      $rose(on_q) && $past(st_q) == ST_DELAY |->
      $past(sec_q) >= $past(delay_q))
      else $error("Restart delay cut short.");
   AST_LOCKOUT_STICKS: assert property (
      st_q == ST_LOCKOUT |=> st_q == ST_LOCKOUT && !on_q &&
      lock_q && err_q == ERR_FB)
      else $error("Lock-out was left or outputs turned on.");
   AST_FB_INTERLOCK: assert property (
      fb_fault_now && cfg_q.restart_mode == RM_INTERLOCK |=>
      !on_q && led_q && err_q == ERR_FB)
      else $error("Contactor fault in interlock mode not reported.");
   AST_UNUSED_ACTIVE: assert property (
      cfg_q.out_mode == OM_UNUSED |=> link_q.out_active)
      else $error("Unused outputs not reported active on the link.");
   AST_UNEVAL_REPORT: assert property (
      !cfg_q.eval_mask[0] |=> link_q.pf1 == !$past(cfg_q.unalloc_infringed))
      else $error("Non-evaluated field reported with the wrong value.");

   COV_OUTPUT_ON:  cover property ($rose(on_q));
   COV_LOCKOUT:    cover property ($rose(lock_q));
   COV_DELAY_DONE: cover property (st_q == ST_DELAY ##1 st_q == ST_ON);
   COV_RESET_USED: cover property (st_q == ST_WAIT_RESET ##1 st_q == ST_ON);

endmodule : sorc_top

// >>> shared/sorc_pkg.sv
package sorc_pkg;

   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int LINE_W     = 4;
   localparam int CASE_W     = 3;

   localparam logic [7:0] OFS_CFG    = 8'h00;
   localparam logic [7:0] OFS_DELAY  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   localparam logic [1:0] RM_NONE      = 2'h0;
   localparam logic [1:0] RM_DELAY     = 2'h1;
   localparam logic [1:0] RM_INTERLOCK = 2'h2;

   localparam logic [1:0] OM_INTERNAL = 2'h0;
   localparam logic [1:0] OM_EXTERNAL = 2'h1;
   localparam logic [1:0] OM_UNUSED   = 2'h2;

   typedef struct packed {
      logic [3:0] eval_mask;
      logic       unalloc_infringed;
      logic       dual_pf;
      logic       fb_mon_en;
      logic [1:0] out_mode;
      logic [1:0] restart_mode;
   } sorc_cfg_t;

   localparam int         CFG_W   = 11;
   localparam logic [10:0] CFG_RST = 11'h180;

   typedef struct packed {
      logic out_active;
      logic pf1;
      logic sim_pf1;
      logic pf2;
      logic sim_pf2;
      logic wf1;
      logic wf2;
   } sorc_link_t;

   localparam int         DELAY_W   = 6;
   localparam logic [5:0] DELAY_MIN = 6'h02;
   localparam logic [5:0] DELAY_MAX = 6'h3c;
   localparam logic [5:0] DELAY_RST = 6'h02;

   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_FB   = 4'h1;
   localparam logic [3:0] ERR_CASE = 4'h2;

   localparam int ST_BIT_ON      = 0;
   localparam int ST_BIT_LOCK    = 1;
   localparam int ST_BIT_RSTREQ  = 2;
   localparam int ST_BIT_FB      = 3;
   localparam int ST_BIT_CASEERR = 4;
   localparam int ST_CASE_LSB    = 5;
   localparam int ST_ERR_LSB     = 8;

   localparam int CLK_HZ        = 250_000_000;
   localparam int FB_SETTLE_MS  = 300;

endpackage : sorc_pkg

// >>> rtl/sorc_sync.sv
`timescale 1ns/1ps
module sorc_sync
   import sorc_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= d_in[i];
               s2_q[i] <= s1_q[i];
            end
         end
      end
   endgenerate

   assign q_out = s2_q;

endmodule : sorc_sync

// >>> rtl/sorc_case_decode.sv
`timescale 1ns/1ps
module sorc_case_decode
   import sorc_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic [LINE_W-1:0] lines_in,
   output logic      [CASE_W-1:0] case_out,
   output logic                   err_out
);

   logic [CASE_W-1:0] case_d;
   logic [CASE_W-1:0] case_q;
   logic              err_d;
   logic              err_q;

   // Bit 0 is line one of pair A, bit 3 line two of pair B.
   function automatic logic [CASE_W-1:0] onehot_case(
      input logic [LINE_W-1:0] l);
      logic [CASE_W-1:0] c;
      c = 3'h0;
      if (l == 4'h1) begin
         c = 3'h1;
      end else if (l == 4'h2) begin
         c = 3'h2;
      end else if (l == 4'h4) begin
         c = 3'h3;
      end else if (l == 4'h8) begin
         c = 3'h4;
      end
      return c;
   endfunction : onehot_case

   always_comb begin
      case_d = onehot_case(lines_in);
      err_d  = (onehot_case(lines_in) == 3'h0);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         case_q <= 3'h0;
         err_q  <= 1'b1;
      end else begin
         case_q <= case_d;
         err_q  <= err_d;
      end
   end

   assign case_out = case_q;
   assign err_out  = err_q;

endmodule : sorc_case_decode

// >>> testbench/sorc_far_side.sv
`timescale 1ns/1ps
module sorc_far_side
   import sorc_pkg::*;
#(
   parameter int RELEASE_CYC  = 3,
   parameter int PLC_HOLD_CYC = 6
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       on_in,
   input  wire logic [6:0] link_in,
   input  wire logic       welded_in,
   output logic            feedback_out,
   output logic            plc_run_out
);
   logic [3:0] rel_q;
   logic [3:0] hold_q;

   // Contactors report released only some cycles after losing power; a
   // welded contact never reports released.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rel_q        <= 4'h0;
         feedback_out <= 1'b1;
      end else if (on_in || welded_in) begin
         rel_q        <= 4'h0;
         feedback_out <= 1'b0;
      end else if (rel_q == 4'(RELEASE_CYC)) begin
         feedback_out <= 1'b1;
      end else begin
         rel_q <= rel_q + 4'h1;
      end
   end

   // The controller judges field bits, so it keeps a restart delay of its own.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_q      <= 4'h0;
         plc_run_out <= 1'b0;
      end else if (link_in[5:2] != 4'hf) begin
         hold_q      <= 4'h0;
         plc_run_out <= 1'b0;
      end else if (hold_q == 4'(PLC_HOLD_CYC)) begin
         plc_run_out <= 1'b1;
      end else begin
         hold_q <= hold_q + 4'h1;
      end
   end
endmodule : sorc_far_side

// >>> testbench/test_sorc_top.sv
`timescale 1ns/1ps
module test_sorc_top
   import sorc_pkg::*;
;
   logic        clk, rst_n, wstb, rstb, rsw, welded, fb, plc_run;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [3:0]  lines, err;
   logic [5:0]  pf;
   logic [6:0]  link;
   logic        sw_on, lockout, led, cerr;
   logic [2:0]  mcase;
   int          failures, total_checks;

   sorc_top #(.TICKS_PER_SEC(10), .FB_SETTLE_CYC(8)) dut (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WSTROBE_IN(wstb), .RSTROBE_IN(rstb),
      .PAIR_A_LINE_ONE_IN(lines[3]), .PAIR_A_LINE_TWO_IN(lines[2]),
      .PAIR_B_LINE_ONE_IN(lines[1]), .PAIR_B_LINE_TWO_IN(lines[0]),
      .RESET_SWITCH_IN(rsw), .CONTACTOR_FEEDBACK_MONITOR_IN(fb),
      .PF1_CLEAR_IN(pf[5]), .SIM_PF1_CLEAR_IN(pf[4]), .PF2_CLEAR_IN(pf[3]),
      .SIM_PF2_CLEAR_IN(pf[2]), .WF1_CLEAR_IN(pf[1]), .WF2_CLEAR_IN(pf[0]),
      .RDATA_OUT(rdata), .SAFETY_SWITCH_OUTPUT_OUT(sw_on),
      .LINK_STATUS_OUT(link), .LOCKOUT_OUT(lockout), .FAULT_LED_OUT(led),
      .ERROR_CODE_OUT(err), .MONITOR_CASE_OUT(mcase),
      .CASE_ERROR_OUT(cerr));

   sorc_far_side far (
      .clk_in(clk), .rst_n_in(rst_n), .on_in(sw_on), .link_in(link),
      .welded_in(welded), .feedback_out(fb), .plc_run_out(plc_run));

   always #2 clk = ~clk;

   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t %s seen %h want %h", $time, m, seen, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wstb  <= 1'b1;
      @(posedge clk);
      wstb  <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rstb <= 1'b1;
      @(posedge clk);
      rstb <= 1'b0;
      #1;
      chk(rdata, exp, "read data");
   endtask : rd

   task drive(input logic [5:0] f);
      @(posedge clk);
      pf <= f;
   endtask : drive

   task automatic wait_lvl(ref logic s, input logic v, input int max);
      int n = 0;
      while (s !== v && n < max) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_lvl

   task press;
      @(posedge clk);
      rsw <= 1'b1;
      tick(4);
      @(posedge clk);
      rsw <= 1'b0;
   endtask : press

   task apply_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
   endtask : apply_reset

   task t_regs;
      rd(OFS_CFG, {21'h0, CFG_RST});
      rd(OFS_DELAY, {26'h0, DELAY_RST});
      rd(8'h0c, 32'h0);
      wr(OFS_DELAY, 32'h1);
      rd(OFS_DELAY, {26'h0, DELAY_MIN});
      wr(OFS_DELAY, 32'h3d);
      rd(OFS_DELAY, {26'h0, DELAY_MAX});
      wr(OFS_DELAY, 32'h2);
      $display("test regs done");
   endtask : t_regs

   task t_case;
      logic [3:0] pat [6];
      pat = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'hc};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         lines <= pat[i];
         tick(5);
         chk(mcase, (i < 4) ? i + 1 : 0, "case");
         chk(cerr, (i >= 4), "case error");
         chk(err, (i >= 4) ? ERR_CASE : ERR_NONE, "case code");
      end
      @(posedge clk);
      lines <= 4'h8;
      tick(5);
      $display("test case done");
   endtask : t_case

   task t_none;
      wait_lvl(sw_on, 1'b1, 40);
      chk(sw_on, 1'b1, "output on");
      drive(6'b011111);
      wait_lvl(sw_on, 1'b0, 5);
      chk(sw_on, 1'b0, "pf1 cut");
      chk(link[5], 1'b0, "pf1 bit");
      drive(6'h3f);
      wait_lvl(sw_on, 1'b1, 4);
      chk(sw_on, 1'b1, "prompt restart");
      drive(6'b101111);
      wait_lvl(sw_on, 1'b0, 5);
      chk(sw_on, 1'b0, "sim pf1 cut");
      drive(6'h3f);
      wr(OFS_CFG, 32'h7a0);
      wait_lvl(sw_on, 1'b1, 10);
      drive(6'b110011);
      tick(6);
      chk(sw_on, 1'b1, "pf2 no cut");
      chk(link[3:2], 2'b00, "pf2 on link");
      drive(6'h3f);
      wr(OFS_CFG, 32'h180);
      $display("test none done");
   endtask : t_none

   task t_link;
      wr(OFS_CFG, 32'h184);
      drive(6'b010101);
      tick(3);
      chk(link[5:0], 6'b011101, "external bits");
      chk(link[3:2], 2'b11, "unevaluated");
      chk(plc_run, 1'b0, "plc held");
      wr(OFS_CFG, 32'h144);
      drive(6'h3f);
      tick(3);
      chk(link[3:2], 2'b00, "unallocated");
      chk(link[5:4], 2'b01, "pf1 unallocated");
      wr(OFS_CFG, 32'h188);
      drive(6'b011111);
      tick(3);
      chk(link[6], 1'b1, "unused active");
      chk(sw_on, 1'b0, "unused output");
      drive(6'h3f);
      wr(OFS_CFG, 32'h180);
      tick(10);
      chk(plc_run, 1'b1, "plc runs");
      $display("test link done");
   endtask : t_link

   task t_delay;
      int n;
      wr(OFS_CFG, 32'h181);
      drive(6'b011111);
      wait_lvl(sw_on, 1'b0, 5);
      drive(6'h3f);
      n = 0;
      while (sw_on !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n >= 20 && n <= 24, 1'b1, "delay span");
      $display("test delay done");
   endtask : t_delay

   task t_interlock;
      wr(OFS_CFG, 32'h182);
      drive(6'b011111);
      wait_lvl(sw_on, 1'b0, 5);
      drive(6'h3f);
      tick(10);
      chk(sw_on, 1'b0, "stays off");
      rd(OFS_STATUS, 32'h0000_0024);
      drive(6'b011111);
      press;
      drive(6'h3f);
      tick(8);
      chk(sw_on, 1'b0, "press ignored");
      press;
      wait_lvl(sw_on, 1'b1, 8);
      chk(sw_on, 1'b1, "press restarts");
      wr(OFS_CFG, 32'h180);
      $display("test interlock done");
   endtask : t_interlock

   task t_feedback;
      apply_reset;
      wr(OFS_CFG, 32'h190);
      wait_lvl(sw_on, 1'b1, 40);
      @(posedge clk);
      welded <= 1'b1;
      drive(6'b011111);
      wait_lvl(lockout, 1'b1, 40);
      chk(lockout, 1'b1, "lockout");
      chk(err, ERR_FB, "feedback code");
      @(posedge clk);
      welded <= 1'b0;
      drive(6'h3f);
      tick(20);
      chk(sw_on, 1'b0, "locked off");
      apply_reset;
      wr(OFS_CFG, 32'h192);
      tick(12);
      press;
      wait_lvl(sw_on, 1'b1, 40);
      @(posedge clk);
      welded <= 1'b1;
      drive(6'b011111);
      wait_lvl(led, 1'b1, 40);
      chk(led, 1'b1, "fault led");
      chk(err, ERR_FB, "feedback code");
      chk(lockout, 1'b0, "no lockout");
      drive(6'h3f);
      press;
      tick(4);
      chk(sw_on, 1'b0, "welded off");
      @(posedge clk);
      welded <= 1'b0;
      apply_reset;
      $display("test feedback done");
   endtask : t_feedback

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wstb, rstb, rsw, welded} = 4'h0;
      addr = 8'h0;
      wdata = 32'h0;
      lines = 4'h8;
      pf = 6'h3f;
      failures = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      t_regs;
      t_case;
      t_none;
      t_link;
      t_delay;
      t_interlock;
      t_feedback;
      report_and_stop;
   end

   initial begin
      #(4 * 20000);
      failures++;
      $display("BAD t=%0t watchdog expired", $time);
      report_and_stop;
   end
endmodule : test_sorc_top
